// File: common/rmli_pkg.sv
// package: constants and types for the reset-mode latch and irq inputs block
`default_nettype none
package rmli_pkg;
	localparam int RMLI_LINES = 4;
	localparam int RMLI_MODE_W = 4;
	localparam int RMLI_MODE_COUNT = 16;
	localparam int RMLI_PHASE_W = 2;
	localparam logic [RMLI_MODE_W-1:0] RMLI_MODE_RST = 4'h0;
	localparam logic [RMLI_LINES-1:0] RMLI_SYNC_RST = 4'hF;
	localparam logic [RMLI_PHASE_W-1:0] RMLI_PHASE_RST = 2'h0;
	localparam int RMLI_SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		RMLI_ST_RESET = 2'b00,
		RMLI_ST_RUN = 2'b01,
		RMLI_ST_STOP = 2'b10
	} rmli_state_t;
endpackage
`default_nettype wire

// File: design/rmli_sync.sv
// two-flop synchroniser for the shared active-low pins
`timescale 1ns/100ps
`default_nettype none
module rmli_sync (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [rmli_pkg::RMLI_LINES-1:0] pin_n_i,
	output logic [rmli_pkg::RMLI_LINES-1:0] sync_n_o
);
	import rmli_pkg::*;
	logic [RMLI_LINES-1:0] meta_r;
	// first flop feeds only the second; reset to the idle-high level
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			meta_r <= RMLI_SYNC_RST;
			sync_n_o <= RMLI_SYNC_RST;
		end else begin
			meta_r <= pin_n_i;
			sync_n_o <= meta_r;
		end
	end
endmodule
`default_nettype wire

// File: design/rmli_top.sv
// mode latch at reset release and maskable external request inputs
`timescale 1ns/100ps
`default_nettype none
module rmli_top (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic mode_sel0_irq0_n_i,
	input wire logic mode_sel1_irq1_n_i,
	input wire logic mode_sel2_irq2_n_i,
	input wire logic mode_sel3_irq3_n_i,
	input wire logic [rmli_pkg::RMLI_LINES-1:0] irq_edge_sel_i,
	input wire logic [rmli_pkg::RMLI_LINES-1:0] irq_mask_i,
	input wire logic [rmli_pkg::RMLI_LINES-1:0] irq_ack_i,
	input wire logic stop_enter_i,
	output logic [rmli_pkg::RMLI_MODE_W-1:0] op_mode_o,
	output logic mode_valid_o,
	output logic [rmli_pkg::RMLI_LINES-1:0] irq_req_o,
	output logic stop_o,
	output logic wake_o,
	output logic [rmli_pkg::RMLI_PHASE_W-1:0] phase_o
);
	import rmli_pkg::*;

	logic [RMLI_LINES-1:0] pins_n;
	logic [RMLI_LINES-1:0] sync_n;
	logic [RMLI_LINES-1:0] prev_n_r;
	logic [RMLI_LINES-1:0] edge_pend_r;
	logic [RMLI_LINES-1:0] edge_pend_nxt;
	logic [RMLI_LINES-1:0] fall_det;
	logic [RMLI_LINES-1:0] active;
	logic [RMLI_LINES-1:0] raw_req;
	logic [RMLI_LINES-1:0] irq_req_nxt;
	logic [RMLI_MODE_W-1:0] mode_code;
	logic [RMLI_MODE_W-1:0] op_mode_nxt;
	logic [RMLI_PHASE_W-1:0] phase_nxt;
	logic in_reset_r;
	logic release_evt;
	logic wake_evt;
	logic run;
	rmli_state_t state_r;
	rmli_state_t state_nxt;

	// a low pin is an asserted line
	function automatic logic [RMLI_LINES-1:0] low_active(input logic [RMLI_LINES-1:0] pin_n);
		return ~pin_n;
	endfunction

	assign pins_n = {mode_sel3_irq3_n_i, mode_sel2_irq2_n_i, mode_sel1_irq1_n_i, mode_sel0_irq0_n_i};

	rmli_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.srst_i(1'b0),
		.pin_n_i(pins_n),
		.sync_n_o(sync_n)
	);

	// synchroniser keeps running under reset so the code is settled at release
	assign active = low_active(sync_n);
	assign mode_code = active;
	// first idle cycle after reset ends is the latch moment
	assign release_evt = in_reset_r & ~srst_i;
	assign op_mode_nxt = release_evt ? mode_code : op_mode_o;
	assign run = (state_r != RMLI_ST_RESET);

	assign fall_det = prev_n_r & low_active(sync_n);
	// a new edge wins over a same-cycle acknowledge
	assign edge_pend_nxt = run ? (fall_det | (edge_pend_r & ~irq_ack_i)) : '0;
	assign raw_req = (irq_edge_sel_i & edge_pend_r) | (~irq_edge_sel_i & active);
	assign irq_req_nxt = (state_r == RMLI_ST_RUN) ? (raw_req & ~irq_mask_i) : '0;
	assign wake_evt = (state_r == RMLI_ST_STOP) & active[0];
	assign phase_nxt = phase_o + 2'h1;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RMLI_ST_RESET: begin
				state_nxt = RMLI_ST_RUN;
			end
			RMLI_ST_RUN: begin
				if (stop_enter_i) begin
					state_nxt = RMLI_ST_STOP;
				end
			end
			RMLI_ST_STOP: begin
				if (wake_evt) begin
					state_nxt = RMLI_ST_RUN;
				end
			end
			default: begin
				state_nxt = RMLI_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			in_reset_r <= 1'b1;
			state_r <= RMLI_ST_RESET;
			prev_n_r <= RMLI_SYNC_RST;
			edge_pend_r <= '0;
			irq_req_o <= '0;
			stop_o <= 1'b0;
			wake_o <= 1'b0;
			mode_valid_o <= 1'b0;
			phase_o <= RMLI_PHASE_RST;
		end else begin
			in_reset_r <= 1'b0;
			state_r <= state_nxt;
			prev_n_r <= sync_n;
			edge_pend_r <= edge_pend_nxt;
			irq_req_o <= irq_req_nxt;
			stop_o <= (state_nxt == RMLI_ST_STOP);
			wake_o <= wake_evt;
			mode_valid_o <= 1'b1;
			phase_o <= phase_nxt;
		end
	end

	// mode register is kept across reset; its value is only meaningful once valid
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			op_mode_o <= op_mode_o;
		end else begin
			op_mode_o <= op_mode_nxt;
		end
	end

	property p_mode_latch;
		@(posedge clk_sys_i) disable iff (srst_i)
		release_evt |=> (op_mode_o == $past(mode_code)) && mode_valid_o;
	endproperty
	a_mode_latch: assert property (p_mode_latch) else $error("mode not latched at release");

	property p_mode_hold;
		@(posedge clk_sys_i) disable iff (srst_i)
		!release_evt && !$past(srst_i) |=> $stable(op_mode_o);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed after release");

	property p_no_irq_reset;
		@(posedge clk_sys_i) srst_i |=> irq_req_o == '0;
	endproperty
	a_no_irq_reset: assert property (p_no_irq_reset) else $error("request during reset");

	property p_phase_reset;
		@(posedge clk_sys_i) srst_i |=> phase_o == RMLI_PHASE_RST && stop_o == 1'b0;
	endproperty
	a_phase_reset: assert property (p_phase_reset) else $error("phase not reset");

	property p_level_req;
		@(posedge clk_sys_i) disable iff (srst_i)
		(state_r == RMLI_ST_RUN) && !irq_edge_sel_i[1] && !irq_mask_i[1] && active[1] |=> irq_req_o[1];
	endproperty
	a_level_req: assert property (p_level_req) else $error("level request missed");

	property p_mask;
		@(posedge clk_sys_i) disable iff (srst_i)
		irq_mask_i[2] |=> !irq_req_o[2];
	endproperty
	a_mask: assert property (p_mask) else $error("masked request passed");

	property p_edge_pend;
		@(posedge clk_sys_i) disable iff (srst_i)
		run && prev_n_r[3] && !sync_n[3] |=> edge_pend_r[3];
	endproperty
	a_edge_pend: assert property (p_edge_pend) else $error("falling edge lost");

	property p_wake;
		@(posedge clk_sys_i) disable iff (srst_i)
		(state_r == RMLI_ST_STOP) && active[0] |=> wake_o && !stop_o;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake from stop");

	property p_sync_delay;
		@(posedge clk_sys_i) disable iff (srst_i)
		$past(srst_i, 3) == 1'b0 |-> sync_n == $past(pins_n, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("synchroniser depth wrong");

	property p_set_wins;
		@(posedge clk_sys_i) disable iff (srst_i)
		run && irq_ack_i[1] && prev_n_r[1] && !sync_n[1] |=> edge_pend_r[1];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("edge lost to same-cycle acknowledge");

	property p_ack_clear;
		@(posedge clk_sys_i) disable iff (srst_i)
		run && irq_ack_i[2] && !(prev_n_r[2] && !sync_n[2]) |=> !edge_pend_r[2];
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear edge");

	property p_edge_req;
		@(posedge clk_sys_i) disable iff (srst_i)
		(state_r == RMLI_ST_RUN) && irq_edge_sel_i[3] && edge_pend_r[3] && !irq_mask_i[3] |=> irq_req_o[3];
	endproperty
	a_edge_req: assert property (p_edge_req) else $error("pending edge not requested");

	property p_level_drop;
		@(posedge clk_sys_i) disable iff (srst_i)
		(state_r == RMLI_ST_RUN) && !irq_edge_sel_i[0] && !active[0] |=> !irq_req_o[0];
	endproperty
	a_level_drop: assert property (p_level_drop) else $error("level request without low pin");

	property p_no_req_stop;
		@(posedge clk_sys_i) disable iff (srst_i)
		(state_r == RMLI_ST_STOP) |=> irq_req_o == '0;
	endproperty
	a_no_req_stop: assert property (p_no_req_stop) else $error("request shown in stop");

	property p_stop_hold;
		@(posedge clk_sys_i) disable iff (srst_i)
		(state_r == RMLI_ST_STOP) && !active[0] |=> stop_o && !wake_o;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("left stop without line 0");

	property p_stop_enter;
		@(posedge clk_sys_i) disable iff (srst_i)
		(state_r == RMLI_ST_RUN) && stop_enter_i |=> stop_o;
	endproperty
	a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");

	property p_phase_step;
		@(posedge clk_sys_i) disable iff (srst_i)
		!srst_i |=> phase_o == $past(phase_o) + 2'h1;
	endproperty
	a_phase_step: assert property (p_phase_step) else $error("phase did not advance");

	property p_reset_flags;
		@(posedge clk_sys_i) srst_i |=> !mode_valid_o && !wake_o && !stop_o;
	endproperty
	a_reset_flags: assert property (p_reset_flags) else $error("flags not cleared in reset");
endmodule
`default_nettype wire

// File: tb/rmli_board.sv
// board model: reset source and interrupt sources on the shared pins
`timescale 1ns/100ps
`default_nettype none
module rmli_board (
	input wire logic clk_sys_i,
	input wire logic hold_i,
	input wire logic [3:0] req_i,
	output logic srst_o,
	output logic [3:0] pin_n_o
);
	// release lags by four edges so the mode code is settled before reset drops
	logic [2:0] cnt_r;
	assign pin_n_o = ~req_i;
	always_ff @(posedge clk_sys_i) begin
		cnt_r <= hold_i ? 3'h0 : (cnt_r == 3'h4 ? cnt_r : cnt_r + 3'h1);
	end
	assign srst_o = hold_i | (cnt_r != 3'h4);
endmodule
`default_nettype wire

// File: tb/rmli_top_test.sv
// self-checking bench for the mode latch and request inputs
`timescale 1ns/100ps
`default_nettype none
module rmli_top_test;
	logic clk_sys_i = 1'b0;
	logic hold = 1'b1;
	logic srst, stop_in = 1'b0, valid, stop, wake;
	logic [3:0] req = 4'h0, edge_sel = 4'h0, mask = 4'h0, ack = 4'h0;
	logic [3:0] pin_n, mode, irq;
	logic [1:0] phase;
	int n_fail = 0;
	int checked = 0;
	// clock runs from time zero, so it is stable through every reset
	initial forever #4 clk_sys_i = ~clk_sys_i;
	rmli_board board (.clk_sys_i(clk_sys_i), .hold_i(hold), .req_i(req), .srst_o(srst), .pin_n_o(pin_n));
	rmli_top dut (.clk_sys_i(clk_sys_i), .srst_i(srst), .mode_sel0_irq0_n_i(pin_n[0]),
		.mode_sel1_irq1_n_i(pin_n[1]), .mode_sel2_irq2_n_i(pin_n[2]), .mode_sel3_irq3_n_i(pin_n[3]),
		.irq_edge_sel_i(edge_sel), .irq_mask_i(mask), .irq_ack_i(ack), .stop_enter_i(stop_in),
		.op_mode_o(mode), .mode_valid_o(valid), .irq_req_o(irq), .stop_o(stop), .wake_o(wake),
		.phase_o(phase));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_mode;
		for (int c = 0; c < 16; c++) begin
			hold = 1'b1;
			req = c[3:0];
			cyc(3);
			check(irq, 4'h0);
			check({2'h0, phase}, 4'h0);
			hold = 1'b0;
			cyc(8);
			check(mode, c[3:0]);
			check({3'h0, valid}, 4'h1);
		end
		req = 4'h0;
		cyc(5);
		$display("mode test done");
	endtask
	task automatic test_level;
		logic [1:0] ph;
		mask = 4'h6;
		req = 4'hF;
		cyc(5);
		check(irq, 4'h9);
		ph = phase;
		mask = 4'h0;
		cyc(2);
		check(irq, 4'hF);
		check({2'h0, phase}, {2'h0, ph + 2'h2});
		req = 4'h0;
		cyc(5);
		check(irq, 4'h0);
		$display("level test done");
	endtask
	task automatic test_edge;
		// edges left pending by the level test are cleared first
		edge_sel = 4'hF;
		mask = 4'h3;
		ack = 4'hF;
		cyc(1);
		ack = 4'h0;
		cyc(2);
		check(irq, 4'h0);
		req = 4'hF;
		cyc(2);
		req = 4'h0;
		cyc(6);
		check(irq, 4'hC);
		ack = 4'hF;
		cyc(1);
		ack = 4'h0;
		cyc(4);
		check(irq, 4'h0);
		// acknowledge in the very cycle the edge is seen
		req = 4'hF;
		cyc(2);
		ack = 4'hF;
		cyc(1);
		ack = 4'h0;
		req = 4'h0;
		cyc(3);
		check(irq, 4'hC);
		ack = 4'hF;
		cyc(1);
		ack = 4'h0;
		mask = 4'h0;
		edge_sel = 4'h0;
		cyc(3);
		check(irq, 4'h0);
		$display("edge test done");
	endtask
	task automatic test_stop;
		int seen;
		seen = 0;
		stop_in = 1'b1;
		cyc(1);
		stop_in = 1'b0;
		req = 4'h2;
		cyc(4);
		check({3'h0, stop}, 4'h1);
		check(irq, 4'h0);
		req = 4'h3;
		repeat (8) begin
			cyc(1);
			if (wake === 1'b1) seen++;
		end
		check(seen[3:0], 4'h1);
		check({3'h0, stop}, 4'h0);
		check(irq, 4'h3);
		req = 4'h0;
		$display("stop test done");
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		cyc(20);
		test_mode();
		test_level();
		test_edge();
		test_stop();
		stop_test();
	end
	initial begin
		#20000;
		n_fail++;
		stop_test();
	end
endmodule
`default_nettype wire
